// *** rtl/serial_flash_program_path.v ***
// program-command logic of a serial flash: sequential, dual and quad program
`timescale 1ns/100ps
`include "flash_prog_map.vh"

// first-word-fall-through fifo between page buffer and array write port
module prog_fifo #(
   parameter WIDTH = 27,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys,
   input wire reset,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] store [0:DEPTH-1]; // word storage
   reg [AW:0] wrPtr; // extra bit tells full from empty
   reg [AW:0] rdPtr;
   wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   wire empty = (wrPtr == rdPtr);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = store[rdPtr[AW-1:0]];
   // write side
   always @(posedge clk_sys) begin
      if (inValid && !full) begin
         store[wrPtr[AW-1:0]] <= inData;
      end
   end
   // pointer update
   always @(posedge clk_sys) begin
      if (reset) begin
         wrPtr <= {(AW+1){1'b0}};
         rdPtr <= {(AW+1){1'b0}};
      end else begin
         if (inValid && !full) wrPtr <= wrPtr + 1'b1;
         if (outReady && !empty) rdPtr <= rdPtr + 1'b1;
      end
   end
endmodule // prog_fifo

// Behaviour
// - sequential mode programs only last byte
// - sequential unaligned release discards byte, clears latch
// - protected sequential start skipped, latch cleared
// - exit sequential before protected block, clear latch
// - no wrap: exit after top address
// - exit when entering erase-suspended block
// - latch cleared ends sequential mode
// - verify failure sets both error flags
// - dual program writes 1-256 bytes
// - command, address msb first on input
// - dual byte: four clocks, output pin high
// - page data wraps within same page
// - program on release; keep last 256
// - dual needs address, whole byte, aligned release
// - protected dual address: no program, clear latch
// - quad data on four pins
// - busy shown during self-timed programming
// - quad byte: two clocks, hold first
// - later sequential frames: command then byte
module serial_flash_program_path #(
   parameter PAGE_PROG_CYCLES = `PAGE_PROGRAM_TIME_US * `CLK_MHZ
) (
   input wire clk_sys,
   input wire reset,
   input wire csN,
   input wire sck,
   input wire siIn,
   input wire soIn,
   output wire soOut,
   output wire soOeN,
   input wire wpIn,
   input wire holdIn,
   input wire writeEnableCmd,
   input wire writeDisableCmd,
   input wire quadEnableBit,
   input wire [7:0] protectMask,
   input wire eraseSuspended,
   input wire [2:0] suspendedBlock,
   input wire errorClear,
   input wire verifyFail,
   output reg writeEnableLatch,
   output wire busyFlag,
   output reg seqMode,
   output reg eraseErrorFlag,
   output reg programErrorFlag,
   output wire memWrValid,
   input wire memWrReady,
   output wire [18:0] memWrAddr,
   output wire [7:0] memWrData
);
   localparam [15:0] BYTE_PROG_CYCLES = `BYTE_PROGRAM_TIME_US * `CLK_MHZ;
   // link phases
   localparam [1:0] PH_CMD = 2'h0;
   localparam [1:0] PH_ADDR = 2'h1;
   localparam [1:0] PH_DATA = 2'h2;
   localparam [1:0] PH_SKIP = 2'h3;
   // program engine states
   localparam [1:0] EN_IDLE = 2'h0;
   localparam [1:0] EN_LOAD = 2'h1;
   localparam [1:0] EN_WAIT = 2'h2;

   // the so pin only ever listens in this block, never driven
   assign soOut = 1'b0;
   assign soOeN = 1'b1;

   // block index of an array address
   function [2:0] blockOf;
      input [18:0] a;
      begin
         blockOf = a[`BLOCK_MSB:`BLOCK_LSB];
      end
   endfunction

   function isSeqCmd;
      input [7:0] c;
      begin
         isSeqCmd = (c == `CMD_SEQ_PROG_A) || (c == `CMD_SEQ_PROG_B);
      end
   endfunction

   reg [5:0] pinMeta; // first stage, read by pinSync only
   reg [5:0] pinSync;
   reg sckPrev;
   reg csPrev;
   // two-flop synchronisers for all pins
   always @(posedge clk_sys) begin
      if (reset) begin
         pinMeta <= 6'h3F;
         pinSync <= 6'h3F;
         sckPrev <= 1'b1;
         csPrev <= 1'b1;
      end else begin
         pinMeta <= {csN, sck, siIn, soIn, wpIn, holdIn};
         pinSync <= pinMeta;
         sckPrev <= pinSync[`PIN_SCK];
         csPrev <= pinSync[`PIN_CS];
      end
   end
   wire csActive = !pinSync[`PIN_CS];
   wire frameStart = csPrev && !pinSync[`PIN_CS];
   wire frameEnd = !csPrev && pinSync[`PIN_CS];
   wire sckRise = csActive && pinSync[`PIN_SCK] && !sckPrev;

   reg [1:0] phase;
   reg [7:0] cmd;
   reg [23:0] addr;
   reg [5:0] bitCnt; // command plus address bits
   reg [7:0] dataShift;
   reg [3:0] bitsIn; // bits of current data byte
   reg gotByte;
   reg [7:0] wrIdx; // in-page write position
   reg [7:0] seqLatch;
   reg [7:0] pageBuf [0:255];
   reg [255:0] bufValid;
   reg [1:0] engState;

   wire [7:0] nextCmd = {cmd[6:0], pinSync[`PIN_SI]};
   // command acceptance: not busy, latch set, mode legal
   wire cmdOk = (engState == EN_IDLE) && writeEnableLatch &&
      (isSeqCmd(nextCmd) || (!seqMode && ((nextCmd == `CMD_DUAL_PROG) ||
      ((nextCmd == `CMD_QUAD_PROG) && quadEnableBit))));
   wire isDual = (cmd == `CMD_DUAL_PROG);
   wire isQuad = (cmd == `CMD_QUAD_PROG);
   // bits taken per clock in the data phase
   wire [3:0] laneBits = isQuad ? 4'h4 : (isDual ? 4'h2 : 4'h1);
   reg [7:0] shifted;
   always @* begin
      if (isQuad) begin
         shifted = {dataShift[3:0], pinSync[`PIN_HOLD], pinSync[`PIN_WP],
            pinSync[`PIN_SO], pinSync[`PIN_SI]};
      end else if (isDual) begin
         shifted = {dataShift[5:0], pinSync[`PIN_SO], pinSync[`PIN_SI]};
      end else begin
         shifted = {dataShift[6:0], pinSync[`PIN_SI]};
      end
   end
   wire byteDone = (bitsIn + laneBits) == 4'h8;

   // frame receiver: command, address, data shifting
   always @(posedge clk_sys) begin
      if (reset) begin
         phase <= PH_CMD;
         cmd <= 8'h00;
         addr <= 24'h00_0000;
         bitCnt <= 6'h00;
         dataShift <= 8'h00;
         bitsIn <= 4'h0;
         gotByte <= 1'b0;
         wrIdx <= 8'h00;
         seqLatch <= 8'h00;
         bufValid <= 256'h0;
      end else if (frameStart) begin
         phase <= PH_CMD;
         bitCnt <= 6'h00;
         bitsIn <= 4'h0;
         gotByte <= 1'b0;
      end else if (sckRise) begin
         case (phase)
            PH_CMD: begin
               cmd <= nextCmd;
               bitCnt <= bitCnt + 6'h01;
               if (bitCnt == `CMD_LAST_BIT) begin
                  if (!cmdOk) begin
                     phase <= PH_SKIP;
                  end else if (isSeqCmd(nextCmd) && seqMode) begin
                     phase <= PH_DATA;
                  end else begin
                     phase <= PH_ADDR;
                     if (!isSeqCmd(nextCmd)) bufValid <= 256'h0;
                  end
               end
            end
            PH_ADDR: begin
               addr <= {addr[22:0], pinSync[`PIN_SI]};
               bitCnt <= bitCnt + 6'h01;
               if (bitCnt == `ADDR_LAST_BIT) begin
                  phase <= PH_DATA;
                  wrIdx <= {addr[6:0], pinSync[`PIN_SI]};
               end
            end
            PH_DATA: begin
               dataShift <= shifted;
               if (byteDone) begin
                  bitsIn <= 4'h0;
                  gotByte <= 1'b1;
                  if (isSeqCmd(cmd)) begin
                     seqLatch <= shifted;
                  end else begin
                     // index wraps inside the page; later bytes overwrite
                     pageBuf[wrIdx] <= shifted;
                     bufValid[wrIdx] <= 1'b1;
                     wrIdx <= wrIdx + 8'h01;
                  end
               end else begin
                  bitsIn <= bitsIn + laneBits;
               end
            end
            default: begin
               phase <= PH_SKIP;
            end
         endcase
      end
   end

   // frame end evaluation
   wire complete = (phase == PH_DATA) && gotByte && (bitsIn == 4'h0);
   wire accepted = (phase == PH_ADDR) || (phase == PH_DATA);
   wire seqFirst = isSeqCmd(cmd) && !seqMode;
   wire startProt = protectMask[blockOf(addr[18:0])] && (seqFirst || !isSeqCmd(cmd));
   wire abortClr = frameEnd && accepted && (!complete || startProt);
   wire progStart = frameEnd && accepted && complete && !startProt;

   reg [18:0] seqAddr; // internal sequential address counter
   reg [10:0] pageBase;
   reg singleByte;
   reg [7:0] loadIdx;
   reg [15:0] timer;
   wire [18:0] seqNext = seqAddr + 19'h0_0001;
   wire fifoInReady;
   wire fifoOutValid;
   wire fifoInValid = (engState == EN_LOAD) && (singleByte || bufValid[loadIdx]);
   wire [26:0] fifoInData = singleByte ? {seqAddr, seqLatch} :
      {pageBase, loadIdx, pageBuf[loadIdx]};
   wire engDone = (engState == EN_WAIT) && (timer == 16'h0000) && !fifoOutValid;
   // exit and page-end clears fire in the engine's last cycle, so the latch drops together with busy
   wire seqLast = (seqAddr == `ARRAY_TOP);
   wire seqHitProt = protectMask[blockOf(seqNext)];
   wire seqExitClr = engDone && singleByte && (seqLast || seqHitProt); // latch clear on top-address or protected-block exit
   wire pageDoneClr = engDone && !singleByte; // latch clear after a page
   // any latch clear this cycle that the enable command does not override
   wire latchClr = !writeEnableCmd && (writeDisableCmd || abortClr || seqExitClr || pageDoneClr);

   // self-timed program engine
   always @(posedge clk_sys) begin
      if (reset) begin
         engState <= EN_IDLE;
         seqAddr <= 19'h0_0000;
         pageBase <= 11'h000;
         singleByte <= 1'b0;
         loadIdx <= 8'h00;
         timer <= 16'h0000;
         seqMode <= 1'b0;
      end else begin
         if (timer != 16'h0000) timer <= timer - 16'h0001;
         case (engState)
            EN_IDLE: begin
               if (progStart) begin
                  engState <= EN_LOAD;
                  loadIdx <= 8'h00;
                  singleByte <= isSeqCmd(cmd);
                  pageBase <= addr[18:8];
                  if (seqFirst) begin
                     seqAddr <= addr[18:0];
                     seqMode <= 1'b1;
                  end
                  timer <= isSeqCmd(cmd) ? BYTE_PROG_CYCLES : PAGE_PROG_CYCLES[15:0];
               end
            end
            EN_LOAD: begin
               // a full fifo stalls the walk through the page buffer
               if (!fifoInValid || fifoInReady) begin
                  loadIdx <= loadIdx + 8'h01;
                  if (singleByte || (loadIdx == 8'hFF)) engState <= EN_WAIT;
               end
            end
            EN_WAIT: begin
               if (engDone) begin
                  engState <= EN_IDLE;
                  if (seqExitClr) begin
                     seqMode <= 1'b0;
                  end else if (singleByte) begin
                     seqAddr <= seqNext;
                     if (eraseSuspended && (blockOf(seqNext) == suspendedBlock)) begin
                        seqMode <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               engState <= EN_IDLE;
            end
         endcase
         // a latch cleared now or earlier ends sequential mode in the same cycle
         if (!writeEnableLatch || latchClr) seqMode <= 1'b0;
      end
   end
   assign busyFlag = (engState != EN_IDLE);

   // write enable latch: the write enable command wins over clears
   always @(posedge clk_sys) begin
      if (reset) begin
         writeEnableLatch <= 1'b0;
      end else if (writeEnableCmd) begin
         writeEnableLatch <= 1'b1;
      end else if (latchClr) begin
         writeEnableLatch <= 1'b0;
      end
   end

   // sticky error flags, a new failure wins over the clear
   always @(posedge clk_sys) begin
      if (reset) begin
         eraseErrorFlag <= 1'b0;
         programErrorFlag <= 1'b0;
      end else if (verifyFail && busyFlag) begin
         eraseErrorFlag <= 1'b1;
         programErrorFlag <= 1'b1;
      end else if (errorClear) begin
         eraseErrorFlag <= 1'b0;
         programErrorFlag <= 1'b0;
      end
   end

   // array write queue, drained by the array at its own pace
   prog_fifo #(
      .WIDTH(27),
      .DEPTH(16),
      .AW(4)
   ) writeQueue (
      .clk_sys(clk_sys),
      .reset(reset),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(memWrReady),
      .outData({memWrAddr, memWrData})
   );
   assign memWrValid = fifoOutValid;
endmodule // serial_flash_program_path

// *** rtl/flash_prog_map.vh ***
// constants for the serial flash program path
`ifndef FLASH_PROG_MAP_VH
`define FLASH_PROG_MAP_VH
// command codes
`define CMD_DUAL_PROG 8'hA2
`define CMD_QUAD_PROG 8'h32
`define CMD_SEQ_PROG_A 8'hAD
`define CMD_SEQ_PROG_B 8'hAF
// array geometry
`define ARRAY_TOP 19'h7_FFFF
`define BLOCK_MSB 18
`define BLOCK_LSB 16
`define PAGE_BYTES 9'h100
// frame bit positions: command ends at 8 bits, address at 32
`define CMD_LAST_BIT 6'h07
`define ADDR_LAST_BIT 6'h1F
// pin sample vector positions
`define PIN_CS 5
`define PIN_SCK 4
`define PIN_SI 3
`define PIN_SO 2
`define PIN_WP 1
`define PIN_HOLD 0
// program times in microseconds, clock in MHz
`define CLK_MHZ 100
`define BYTE_PROGRAM_TIME_US 10
`define PAGE_PROGRAM_TIME_US 100
`endif

// *** testbench/spi_host_model.sv ***
// host controller model driving program frames onto the flash pins
`timescale 1ns/100ps
module spi_host_model (
   output logic csN,
   output logic sck,
   output logic siIn,
   output logic soIn,
   output logic wpIn,
   output logic holdIn
);
   // select idle high, clock parked low outside frames
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      {holdIn, wpIn, soIn, siIn} = 4'b1010;
   end
   // one 160 ns link clock, lines held across the rising edge
   task clk1(input logic [3:0] pins);
      {holdIn, wpIn, soIn, siIn} = pins;
      #80 sck = 1'b1;
      #80 sck = 1'b0;
   endtask
   // single-lane bits, most significant first
   task serial(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) clk1({3'b101, v[i]});
   endtask
   // two lanes: upper bit of each pair on the output pin
   task dual(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) clk1({2'b10, b[7 - 2 * i], b[6 - 2 * i]});
   endtask
   // four lanes, hold pin carries the top bit
   task quad(input logic [7:0] b);
      clk1(b[7:4]);
      clk1(b[3:0]);
   endtask
   task frameStart();
      csN = 1'b0;
      #160;
   endtask
   // released lines flip so a stale level never looks valid
   task frameEnd();
      #80 csN = 1'b1;
      {holdIn, wpIn, soIn, siIn} = ~{holdIn, wpIn, soIn, siIn};
      #480;
   endtask
endmodule // spi_host_model

// *** testbench/serial_flash_program_path_props.sv ***
// port checker for the serial flash program path
`timescale 1ns/100ps
module serial_flash_program_path_props (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic writeEnableCmd,
   input wire logic writeDisableCmd,
   input wire logic errorClear,
   input wire logic soOeN,
   input wire logic writeEnableLatch,
   input wire logic busyFlag,
   input wire logic seqMode,
   input wire logic eraseErrorFlag,
   input wire logic programErrorFlag,
   input wire logic memWrValid,
   input wire logic memWrReady,
   input wire logic [18:0] memWrAddr,
   input wire logic [7:0] memWrData
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // a word offered and refused, and a word handed over
   sequence wordHeld; memWrValid && !memWrReady; endsequence
   sequence wordTaken; memWrValid && memWrReady; endsequence
   so_input_only_a: assert property (soOeN == 1'b1)
      else $error("serial output pin driven");
   word_hold_a: assert property (wordHeld |=> memWrValid && $stable(memWrAddr) && $stable(memWrData))
      else $error("array word changed before taken");
   page_stays_a: assert property (wordTaken ##1 memWrValid |-> memWrAddr[18:8] == $past(memWrAddr[18:8]))
      else $error("burst left its page");
   write_busy_a: assert property (memWrValid |-> busyFlag)
      else $error("array write while not busy");
   error_pair_a: assert property (eraseErrorFlag == programErrorFlag)
      else $error("error flags disagree");
   error_sticky_a: assert property (programErrorFlag && !errorClear |=> programErrorFlag)
      else $error("error flag dropped");
   latch_set_a: assert property (writeEnableCmd |=> writeEnableLatch)
      else $error("latch not set");
   latch_clear_a: assert property (writeDisableCmd && !writeEnableCmd |=> !writeEnableLatch && !seqMode)
      else $error("latch or mode not cleared");
   seq_latch_a: assert property (seqMode |-> writeEnableLatch)
      else $error("sequential mode without latch");
endmodule // serial_flash_program_path_props
bind serial_flash_program_path serial_flash_program_path_props i_props (.clk_sys, .reset, .writeEnableCmd,
   .writeDisableCmd, .errorClear, .soOeN, .writeEnableLatch, .busyFlag, .seqMode, .eraseErrorFlag,
   .programErrorFlag, .memWrValid, .memWrReady, .memWrAddr, .memWrData);

// *** testbench/tb_top.sv ***
// self-checking bench for the serial flash program path
`timescale 1ns/100ps
`include "flash_prog_map.vh"
module tb_top;
   logic clk_sys, reset, stall, quadEnableBit, eraseSuspended, memWrReady;
   logic writeEnableCmd, writeDisableCmd, errorClear, verifyFail;
   logic [7:0] protectMask;
   logic [2:0] suspendedBlock;
   wire csN, sck, siIn, soIn, wpIn, holdIn, soOut, soOeN, writeEnableLatch, busyFlag, seqMode;
   wire eraseErrorFlag, programErrorFlag, memWrValid;
   wire [18:0] memWrAddr;
   wire [7:0] memWrData;
   int fail_count, n_checks, k;
   logic [7:0] expMem [int]; // expected byte per array address
   logic [18:0] gotA [$];
   logic [7:0] gotD [$];
   // page rows: command, start, bytes sent, first byte, lanes, words expected
   typedef struct {logic [7:0] cmd; logic [18:0] a; int n; logic [7:0] d0; int mode; int nExp;} prow_t;
   prow_t prow [4] = '{'{`CMD_DUAL_PROG, 19'h0_0100, 1, 8'h5A, 1, 1},
      '{`CMD_DUAL_PROG, 19'h0_00FE, 3, 8'hC3, 1, 3},
      '{`CMD_QUAD_PROG, 19'h2_0010, 4, 8'h96, 2, 4},
      '{`CMD_DUAL_PROG, 19'h3_0000, 258, 8'h10, 1, 256}};
   // sequential rows: start, protection, suspend, words expected, latch after
   typedef struct {logic [18:0] a; logic [7:0] mask; logic susp; int nExp; logic lat;} srow_t;
   srow_t srow [4] = '{'{19'h1_FFFF, 8'h04, 1'b0, 1, 1'b0},
      '{19'h7_FFFF, 8'h00, 1'b0, 1, 1'b0},
      '{19'h2_FFFF, 8'h00, 1'b1, 1, 1'b1},
      '{19'h0_0010, 8'h01, 1'b0, 0, 1'b0}};
   serial_flash_program_path #(.PAGE_PROG_CYCLES(20)) i_dut (.clk_sys, .reset, .csN, .sck, .siIn, .soIn, .soOut,
      .soOeN, .wpIn, .holdIn, .writeEnableCmd, .writeDisableCmd, .quadEnableBit, .protectMask, .eraseSuspended,
      .suspendedBlock, .errorClear, .verifyFail, .writeEnableLatch, .busyFlag, .seqMode, .eraseErrorFlag,
      .programErrorFlag, .memWrValid, .memWrReady, .memWrAddr, .memWrData);
   spi_host_model i_host (.csN, .sck, .siIn, .soIn, .wpIn, .holdIn);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // array side takes every other cycle, none while stalled
   always @(negedge clk_sys) memWrReady <= !stall && (memWrReady !== 1'b1);
   // log each word handed over
   always @(posedge clk_sys) begin
      if (memWrValid === 1'b1 && memWrReady) begin
         gotA.push_back(memWrAddr);
         gotD.push_back(memWrData);
      end
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one-cycle strobes: enable, disable, error clear, verify fail
   task pulse(input logic [3:0] p);
      @(negedge clk_sys) {writeEnableCmd, writeDisableCmd, errorClear, verifyFail} = p;
      @(negedge clk_sys) {writeEnableCmd, writeDisableCmd, errorClear, verifyFail} = 4'h0;
   endtask
   // bounded wait for the self-timed cycle and drain to end
   task waitIdle();
      repeat (10) @(negedge clk_sys);
      for (k = 0; k < 5000 && busyFlag !== 1'b0; k++) @(negedge clk_sys);
      if (k == 5000) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   // lanes: -1 serial data without address, 0 serial, 1 dual, 2 quad
   task automatic sendProg(input logic [7:0] cmd, input logic [18:0] a, input int n, input logic [7:0] d0,
      input int mode, input bit we);
      logic [7:0] d;
      if (we) pulse(4'h8);
      i_host.frameStart();
      i_host.serial({24'h0, cmd}, 8);
      if (mode >= 0) i_host.serial({13'h0, a}, 24);
      for (int j = 0; j < n; j++) begin
         // bytes past 256 differ from the ones they overwrite
         d = d0 + j[7:0] + j[15:8];
         if (mode == 1) i_host.dual(d, 4);
         else if (mode == 2) i_host.quad(d);
         else i_host.serial({24'h0, d}, 8);
         if (mode > 0) expMem[int'({a[18:8], a[7:0] + j[7:0]})] = d;
      end
      i_host.frameEnd();
   endtask
   task checkWrites(input int n);
      check("word count", gotA.size(), n);
      foreach (gotA[i]) begin
         check("word addr", expMem.exists(int'(gotA[i])), 1);
         check("word data", gotD[i], expMem.exists(int'(gotA[i])) ? expMem[int'(gotA[i])] : 8'hxx);
      end
      gotA.delete();
      gotD.delete();
      expMem.delete();
   endtask
   initial begin
      {reset, stall, quadEnableBit, eraseSuspended} = 4'h8;
      {writeEnableCmd, writeDisableCmd, errorClear, verifyFail} = 4'h0;
      protectMask = 8'h00;
      suspendedBlock = 3'h3;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      repeat (3) @(negedge clk_sys);
      check("reset outputs", {soOut, soOeN, writeEnableLatch, busyFlag, seqMode, eraseErrorFlag, programErrorFlag,
         memWrValid}, 8'h40);
      sendProg(`CMD_DUAL_PROG, 19'h0_0100, 1, 8'h11, 1, 0);
      waitIdle();
      expMem.delete();
      checkWrites(0);
      sendProg(`CMD_QUAD_PROG, 19'h0_0100, 1, 8'h22, 2, 1);
      waitIdle();
      expMem.delete();
      checkWrites(0);
      check("latch kept", writeEnableLatch, 1);
      pulse(4'h4);
      quadEnableBit = 1'b1;
      protectMask = 8'h02;
      sendProg(`CMD_DUAL_PROG, 19'h1_0000, 1, 8'h33, 1, 1);
      waitIdle();
      expMem.delete();
      checkWrites(0);
      check("latch after protect", writeEnableLatch, 0);
      protectMask = 8'h00;
      pulse(4'h8);
      i_host.frameStart();
      i_host.serial({24'h0, `CMD_DUAL_PROG}, 8);
      i_host.serial(32'h0000_0200, 24);
      i_host.dual(8'h44, 2);
      i_host.frameEnd();
      waitIdle();
      checkWrites(0);
      check("latch after partial", writeEnableLatch, 0);
      foreach (prow[r]) begin
         sendProg(prow[r].cmd, prow[r].a, prow[r].n, prow[r].d0, prow[r].mode, 1);
         waitIdle();
         check("latch after page", writeEnableLatch, 0);
         checkWrites(prow[r].nExp);
      end
      stall = 1'b1;
      sendProg(`CMD_DUAL_PROG, 19'h0_0400, 1, 8'hAA, 1, 1);
      repeat (20) @(negedge clk_sys);
      check("busy while stalled", busyFlag, 1);
      sendProg(`CMD_DUAL_PROG, 19'h0_0500, 1, 8'hBB, 1, 1);
      expMem.delete(int'(19'h0_0500));
      stall = 1'b0;
      waitIdle();
      checkWrites(1);
      pulse(4'h4);
      sendProg(`CMD_SEQ_PROG_A, 19'h4_0010, 2, 8'h11, 0, 1);
      expMem[int'(19'h4_0010)] = 8'h12;
      repeat (50) @(negedge clk_sys);
      pulse(4'h1);
      waitIdle();
      checkWrites(1);
      check("seq mode on", seqMode, 1);
      check("error flags", {eraseErrorFlag, programErrorFlag}, 2'b11);
      sendProg(`CMD_SEQ_PROG_B, 19'h0_0000, 1, 8'h77, -1, 0);
      expMem[int'(19'h4_0011)] = 8'h77;
      waitIdle();
      checkWrites(1);
      pulse(4'h2);
      check("errors cleared", {eraseErrorFlag, programErrorFlag}, 2'b00);
      i_host.frameStart();
      i_host.serial({24'h0, `CMD_SEQ_PROG_B}, 8);
      i_host.serial(32'h0000_0ABC, 12);
      i_host.frameEnd();
      waitIdle();
      checkWrites(0);
      check("seq abort", {writeEnableLatch, seqMode}, 2'b00);
      foreach (srow[r]) begin
         protectMask = srow[r].mask;
         eraseSuspended = srow[r].susp;
         sendProg(`CMD_SEQ_PROG_A, srow[r].a, 1, 8'h5C, 0, 1);
         if (srow[r].nExp > 0) expMem[int'(srow[r].a)] = 8'h5C;
         waitIdle();
         checkWrites(srow[r].nExp);
         check("seq exit", {seqMode, writeEnableLatch}, {1'b0, srow[r].lat});
         pulse(4'h4);
      end
      report_and_stop();
   end
endmodule // tb_top
